// ---- logic/mmac_top.sv ----
/*
 * Nibble-wide 10/100 Ethernet MAC: AHB-Lite configuration, transmit engine with pause
 * frame origination, receive engine with pause and unicast address matching.
 * Assumes PHY nibble clocks far slower than hclk (at least six hclk per half period).
 */
// Register access over AHB-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
// Behaviour
// - each setting comes from registers or from configuration vectors, per build, except the pause quanta, which always comes from its register
// - transmit and receive duplex are set independently
// - flow control settable freely but acts only in full duplex
// - received pause frames match destination against the pause address or the reserved pause multicast address
// - originated pause frames carry the pause address as source
// - vector builds hold separate receive and transmit pause addresses
// - filter builds match every destination against a separate unicast address
// - bridging enable exists only in register builds
// - the PHY transmit clock paces all transmit logic
// - the PHY receive clock paces all receive logic
// - transmit ready accepts a byte at most every other nibble clock
// - receive valid pulses at most once per two nibbles, except the last byte of a frame, one nibble after the byte before it
// - transmit pins are driven straight from flip-flops
// - receive pins are registered before any logic reads them
// - each instance owns its own transmit and receive clock inputs
// - vector changes act only after the current frame ends
module mmac_top import mmac_pkg::*; #(
	parameter int MGMT_EN = 1,
	parameter int FILTER_EN = 1
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write strobe
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic [31:0] hrdata, // read data
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	input wire logic [TXV_W-1:0] tx_cfg_vec, // static transmit settings
	input wire logic [RXV_W-1:0] rx_cfg_vec, // static receive settings
	input wire logic pause_req, // request a pause frame
	input wire logic [7:0] tx_axis_tdata, // transmit byte
	input wire logic tx_axis_tvalid, // transmit byte valid
	input wire logic tx_axis_tlast, // last byte of frame
	output logic tx_axis_tready, // byte taken
	output logic [7:0] rx_axis_tdata, // received byte
	output logic rx_axis_tvalid, // received byte valid
	output logic rx_axis_tlast, // last byte of frame
	output logic rx_axis_tuser, // frame bad
	output logic rx_pause, // pause frame received
	output logic rx_da_match, // last frame hit unicast address
	input wire logic mii_tx_clk, // PHY transmit clock
	output logic [3:0] mii_txd, // transmit nibble
	output logic mii_tx_en, // transmit enable
	input wire logic mii_rx_clk, // PHY receive clock
	input wire logic [3:0] mii_rxd, // receive nibble
	input wire logic mii_rx_dv, // receive data valid
	input wire logic mii_rx_er // receive error
);
	if (!(MGMT_EN inside {0, 1}) || !(FILTER_EN inside {0, 1})) begin : g_chk
		$error("mmac_top: MGMT_EN and FILTER_EN must be 0 or 1");
	end

	// ------------------------------------------------------------------
	// pad capture and link clock edges
	// ------------------------------------------------------------------
	logic [6:0] rxs_q;
	logic [6:0] rxs_fall;
	logic [6:0] txs_fall;
	mmac_sync #(.W(7)) u_rx_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({mii_rx_clk, mii_rx_er, mii_rx_dv, mii_rxd}),
		.q(rxs_q),
		.rise(),
		.fall(rxs_fall)
	);
	mmac_sync #(.W(7)) u_tx_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d({mii_tx_clk, 6'h00}),
		.q(),
		.rise(),
		.fall(txs_fall)
	);
	wire tx_slot = txs_fall[6];
	wire rx_slot = rxs_fall[6];
	wire rxs_er = rxs_q[5];
	wire rxs_dv = rxs_q[4];
	wire [3:0] rxs_d = rxs_q[3:0];

	// ------------------------------------------------------------------
	// AHB-Lite slave
	// ------------------------------------------------------------------
	logic [3:0] tx_cfg_r;
	logic [2:0] rx_cfg_r;
	logic [47:0] tx_pa_r, rx_pa_r, uc_r;
	logic [15:0] quanta_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;
	logic [31:0] rd_word;
	logic [15:0] under_cnt_r, pause_cnt_r;
	mmac_tx_e tx_st;
	mmac_rx_e rx_st;
	logic pause_pend_r, tx_avb_a;
	wire take = hsel & hready & htrans[1] & (hsize == 3'b010);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= take & hwrite;
			if (take) begin
				wr_addr_r <= haddr[7:0];
			end
			if (take & ~hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	always_comb begin
		case (haddr[7:0])
			REG_TX_CFG: rd_word = {28'h0, tx_cfg_r};
			REG_RX_CFG: rd_word = {29'h0, rx_cfg_r};
			REG_TX_PA_LO: rd_word = tx_pa_r[31:0];
			REG_TX_PA_HI: rd_word = {16'h0, tx_pa_r[47:32]};
			REG_RX_PA_LO: rd_word = rx_pa_r[31:0];
			REG_RX_PA_HI: rd_word = {16'h0, rx_pa_r[47:32]};
			REG_UC_LO: rd_word = uc_r[31:0];
			REG_UC_HI: rd_word = {16'h0, uc_r[47:32]};
			REG_QUANTA: rd_word = {16'h0, quanta_r};
			REG_STATUS: rd_word = {26'h0, tx_avb_a, rx_da_match, pause_pend_r,
				rx_st == RX_BODY, tx_st != TX_IDLE, tx_st == TX_GAP};
			REG_COUNT: rd_word = {pause_cnt_r, under_cnt_r};
			default: rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_cfg_r <= TX_CFG_RST;
			rx_cfg_r <= RX_CFG_RST;
			tx_pa_r <= ADDR_RST;
			rx_pa_r <= ADDR_RST;
			uc_r <= ADDR_RST;
			quanta_r <= QUANTA_RST;
		end else if (wr_pend_r) begin
			case (wr_addr_r)
				REG_TX_CFG: tx_cfg_r <= hwdata[3:0];
				REG_RX_CFG: rx_cfg_r <= hwdata[2:0];
				REG_TX_PA_LO: tx_pa_r[31:0] <= hwdata;
				REG_TX_PA_HI: tx_pa_r[47:32] <= hwdata[15:0];
				REG_RX_PA_LO: rx_pa_r[31:0] <= hwdata;
				REG_RX_PA_HI: rx_pa_r[47:32] <= hwdata[15:0];
				REG_UC_LO: uc_r[31:0] <= hwdata;
				REG_UC_HI: uc_r[47:32] <= hwdata[15:0];
				REG_QUANTA: quanta_r <= hwdata[15:0];
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// active configuration, reloaded only between frames
	// ------------------------------------------------------------------
	logic tx_en_a, tx_hd_a, tx_fc_a, rx_en_a, rx_hd_a, rx_fc_a;
	logic [47:0] tx_pa_a, rx_pa_a, uc_a;
	wire m = (MGMT_EN == 1);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{tx_en_a, tx_hd_a, tx_fc_a, tx_avb_a} <= 4'h0;
			tx_pa_a <= ADDR_RST;
		end else if (tx_st == TX_IDLE) begin
			tx_en_a <= m ? tx_cfg_r[CFG_EN_BIT] : tx_cfg_vec[VEC_EN_BIT];
			tx_hd_a <= m ? tx_cfg_r[CFG_HD_BIT] : tx_cfg_vec[VEC_HD_BIT];
			tx_fc_a <= m ? tx_cfg_r[CFG_FC_BIT] : tx_cfg_vec[VEC_FC_BIT];
			tx_avb_a <= m & tx_cfg_r[CFG_AVB_BIT];
			tx_pa_a <= m ? tx_pa_r : tx_cfg_vec[47:0];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{rx_en_a, rx_hd_a, rx_fc_a} <= 3'h0;
			rx_pa_a <= ADDR_RST;
			uc_a <= ADDR_RST;
		end else if (rx_st != RX_BODY) begin
			rx_en_a <= m ? rx_cfg_r[CFG_EN_BIT] : rx_cfg_vec[VEC_EN_BIT];
			rx_hd_a <= m ? rx_cfg_r[CFG_HD_BIT] : rx_cfg_vec[VEC_HD_BIT];
			rx_fc_a <= m ? rx_cfg_r[CFG_FC_BIT] : rx_cfg_vec[VEC_FC_BIT];
			rx_pa_a <= m ? rx_pa_r : rx_cfg_vec[47:0];
			uc_a <= m ? uc_r : rx_cfg_vec[VEC_UC_LSB +: 48];
		end
	end

	// ------------------------------------------------------------------
	// transmit engine
	// ------------------------------------------------------------------
	function automatic logic [7:0] pause_byte(input logic [5:0] idx, input logic [47:0] sa,
		input logic [15:0] q);
		logic [7:0] b;
		b = 8'h00;
		if (idx < 6'd6) begin
			b = 8'(PAUSE_DA >> (8 * idx));
		end else if (idx < 6'd12) begin
			b = 8'(sa >> (8 * (idx - 6'd6)));
		end else begin
			case (idx)
				6'd12: b = PAUSE_TYPE[15:8];
				6'd13: b = PAUSE_TYPE[7:0];
				6'd14: b = PAUSE_OPCODE[15:8];
				6'd15: b = PAUSE_OPCODE[7:0];
				6'd16: b = q[15:8];
				6'd17: b = q[7:0];
				default: b = 8'h00;
			endcase
		end
		return b;
	endfunction

	logic [7:0] cur_r;
	logic nib_hi_r, last_r, src_p_r;
	logic [3:0] pcnt_r;
	logic [5:0] bidx_r;
	logic [4:0] gcnt_r;
	wire fc_on = tx_fc_a & ~tx_hd_a;
	wire start_p = tx_slot & (tx_st == TX_IDLE) & tx_en_a & pause_pend_r & fc_on;
	wire start_u = tx_slot & (tx_st == TX_IDLE) & tx_en_a & ~start_p & tx_axis_tvalid;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pause_pend_r <= 1'b0;
		end else if (pause_req & fc_on) begin
			pause_pend_r <= 1'b1;
		end else if (start_p | ~fc_on) begin
			pause_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_st <= TX_IDLE;
			cur_r <= 8'h00;
			{nib_hi_r, last_r, src_p_r} <= 3'b000;
			pcnt_r <= 4'h0;
			bidx_r <= 6'h00;
			gcnt_r <= 5'h00;
			tx_axis_tready <= 1'b0;
			mii_txd <= 4'h0;
			mii_tx_en <= 1'b0;
			under_cnt_r <= 16'h0;
		end else begin
			tx_axis_tready <= 1'b0;
			if (tx_axis_tready) begin
				if (tx_axis_tvalid) begin
					cur_r <= tx_axis_tdata;
					last_r <= tx_axis_tlast;
				end else begin
					tx_st <= TX_GAP;
					gcnt_r <= 5'h00;
					under_cnt_r <= under_cnt_r + 16'h1;
				end
			end else if (tx_slot) begin
				case (tx_st)
					TX_IDLE: begin
						mii_tx_en <= 1'b0;
						if (start_p | start_u) begin
							tx_st <= TX_PRE;
							src_p_r <= start_p;
							cur_r <= PREAMBLE;
							{nib_hi_r, last_r} <= 2'b00;
							pcnt_r <= 4'h0;
							bidx_r <= 6'h00;
						end
					end
					TX_PRE, TX_BODY: begin
						nib_hi_r <= ~nib_hi_r;
						if (!nib_hi_r) begin
							mii_txd <= cur_r[3:0];
							mii_tx_en <= 1'b1;
						end else begin
							mii_txd <= cur_r[7:4];
							if (last_r) begin
								tx_st <= TX_GAP;
								gcnt_r <= 5'h00;
							end else if (tx_st == TX_PRE && pcnt_r != PRE_BYTES - 4'd1) begin
								pcnt_r <= pcnt_r + 4'd1;
								cur_r <= (pcnt_r == PRE_BYTES - 4'd2) ? SFD : PREAMBLE;
							end else begin
								tx_st <= TX_BODY;
								if (src_p_r) begin
									cur_r <= pause_byte(bidx_r, tx_pa_a, quanta_r);
									last_r <= (bidx_r == PAUSE_LEN - 6'd1);
									bidx_r <= bidx_r + 6'd1;
								end else begin
									tx_axis_tready <= 1'b1;
								end
							end
						end
					end
					TX_GAP: begin
						mii_tx_en <= 1'b0;
						gcnt_r <= gcnt_r + 5'd1;
						if (gcnt_r == GAP_NIB - 5'd1) begin
							tx_st <= TX_IDLE;
						end
					end
					default: tx_st <= TX_IDLE;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// receive engine
	// ------------------------------------------------------------------
	logic [3:0] prev_r, lo_r;
	logic rnib_r, have_r, bad_r, pa_ok_r, mc_ok_r, uc_ok_r, ty_ok_r;
	logic [7:0] held_r;
	logic [5:0] bcnt_r;
	wire [7:0] rx_byte = {rxs_d, lo_r};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rx_st <= RX_WAIT;
			{prev_r, lo_r} <= 8'h00;
			{rnib_r, have_r, bad_r} <= 3'b000;
			{pa_ok_r, mc_ok_r, uc_ok_r, ty_ok_r} <= 4'h0;
			held_r <= 8'h00;
			bcnt_r <= 6'h00;
			rx_axis_tdata <= 8'h00;
			{rx_axis_tvalid, rx_axis_tlast, rx_axis_tuser} <= 3'b000;
			{rx_pause, rx_da_match} <= 2'b00;
			pause_cnt_r <= 16'h0;
		end else begin
			rx_axis_tvalid <= 1'b0;
			rx_pause <= 1'b0;
			if (rx_slot) begin
				case (rx_st)
					RX_WAIT: begin
						if (!rxs_dv) begin
							rx_st <= RX_HUNT;
						end
					end
					RX_HUNT: begin
						prev_r <= rxs_dv ? rxs_d : 4'h0;
						if (!rx_en_a) begin
							rx_st <= RX_WAIT;
						end else if (rxs_dv && rxs_d == SFD[7:4] && prev_r == PREAMBLE[3:0]) begin
							rx_st <= RX_BODY;
							{rnib_r, have_r, bad_r} <= 3'b000;
							{pa_ok_r, mc_ok_r, uc_ok_r, ty_ok_r} <= 4'hf;
							bcnt_r <= 6'h00;
						end
					end
					RX_BODY: begin
						if (!rxs_dv) begin
							rx_st <= RX_HUNT;
							prev_r <= 4'h0;
							if (have_r) begin
								rx_axis_tdata <= held_r;
								{rx_axis_tvalid, rx_axis_tlast} <= 2'b11;
								rx_axis_tuser <= bad_r | rnib_r;
							end
							if ((pa_ok_r | mc_ok_r) & ty_ok_r & (bcnt_r >= HDR_BYTES) &
								rx_fc_a & ~rx_hd_a) begin
								rx_pause <= 1'b1;
								pause_cnt_r <= pause_cnt_r + 16'h1;
							end
							rx_da_match <= (FILTER_EN == 1) & uc_ok_r;
						end else begin
							if (rxs_er) begin
								bad_r <= 1'b1;
							end
							rnib_r <= ~rnib_r;
							if (!rnib_r) begin
								lo_r <= rxs_d;
							end else begin
								if (have_r) begin
									rx_axis_tdata <= held_r;
									{rx_axis_tvalid, rx_axis_tlast} <= 2'b10;
									rx_axis_tuser <= 1'b0;
								end
								held_r <= rx_byte;
								have_r <= 1'b1;
								if (bcnt_r != 6'h3f) begin
									bcnt_r <= bcnt_r + 6'd1;
								end
								if (bcnt_r < 6'd6) begin
									if (rx_byte != 8'(rx_pa_a >> (8 * bcnt_r))) pa_ok_r <= 1'b0;
									if (rx_byte != 8'(PAUSE_DA >> (8 * bcnt_r))) mc_ok_r <= 1'b0;
									if (rx_byte != 8'(uc_a >> (8 * bcnt_r))) uc_ok_r <= 1'b0;
								end
								if (bcnt_r == 6'd12 && rx_byte != PAUSE_TYPE[15:8]) ty_ok_r <= 1'b0;
								if (bcnt_r == 6'd13 && rx_byte != PAUSE_TYPE[7:0]) ty_ok_r <= 1'b0;
							end
						end
					end
					default: rx_st <= RX_WAIT;
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence s_take;
		tx_axis_tready;
	endsequence
	sequence s_quiet;
		!tx_axis_tready [*8];
	endsequence
	tready_gap_a: assert property (@(posedge hclk) disable iff (!hresetn) s_take |=> s_quiet)
		else $error("transmit ready repeated too soon");
	rx_valid_gap_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_axis_tvalid |=> !rx_axis_tvalid [*6])
		else $error("receive valid repeated too soon");
	rx_pause_fd_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rx_pause |-> rx_fc_a && !rx_hd_a)
		else $error("pause seen outside full duplex with flow control");
	pause_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		start_p |-> tx_fc_a && !tx_hd_a && pause_pend_r)
		else $error("pause frame started without full duplex flow control");
	txd_slot_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$changed(mii_txd) |-> $past(tx_slot))
		else $error("transmit nibble moved off a link edge");
	low_first_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_slot && tx_st == TX_BODY && !nib_hi_r && !tx_axis_tready) |=> mii_txd == $past(cur_r[3:0]))
		else $error("low nibble not sent first");
	cfg_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_st != TX_IDLE && $past(tx_st) != TX_IDLE) |-> $stable(tx_hd_a) && $stable(tx_pa_a))
		else $error("transmit setting changed mid frame");
	pause_sa_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_slot && src_p_r && tx_st == TX_BODY && nib_hi_r && bidx_r == 6'd6)
		|=> cur_r == tx_pa_a[7:0])
		else $error("pause source address not inserted");
	avb_mgmt_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tx_avb_a |-> MGMT_EN == 1)
		else $error("bridging enabled without register interface");
	gap_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(tx_slot && tx_st == TX_GAP) |=> !mii_tx_en)
		else $error("transmit enable high during gap");
endmodule

// ---- include/mmac_pkg.sv ----
/*
 * Shared constants for the nibble-wide Ethernet MAC: register offsets, configuration bit
 * positions, reset values, frame bytes and state encodings.
 * Assumes a 32-bit AHB-Lite register bus and a PHY that sources both nibble clocks.
 */
package mmac_pkg;
	// ------------------------------------------------------------------
	// register offsets (byte addresses)
	// ------------------------------------------------------------------
	localparam logic [7:0] REG_TX_CFG = 8'h00;
	localparam logic [7:0] REG_RX_CFG = 8'h04;
	localparam logic [7:0] REG_TX_PA_LO = 8'h08;
	localparam logic [7:0] REG_TX_PA_HI = 8'h0c;
	localparam logic [7:0] REG_RX_PA_LO = 8'h10;
	localparam logic [7:0] REG_RX_PA_HI = 8'h14;
	localparam logic [7:0] REG_UC_LO = 8'h18;
	localparam logic [7:0] REG_UC_HI = 8'h1c;
	localparam logic [7:0] REG_QUANTA = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_COUNT = 8'h28;
	// ------------------------------------------------------------------
	// configuration fields and reset values
	// ------------------------------------------------------------------
	localparam int CFG_EN_BIT = 0;
	localparam int CFG_HD_BIT = 1;
	localparam int CFG_FC_BIT = 2;
	localparam int CFG_AVB_BIT = 3;
	localparam logic [3:0] TX_CFG_RST = 4'h0;
	localparam logic [2:0] RX_CFG_RST = 3'h0;
	localparam logic [47:0] ADDR_RST = 48'h0;
	localparam logic [15:0] QUANTA_RST = 16'hffff;
	// vector layout: {fc, hd, en, pause addr} and {uc addr, fc, hd, en, pause addr}
	localparam int TXV_W = 51;
	localparam int RXV_W = 99;
	localparam int VEC_EN_BIT = 48;
	localparam int VEC_HD_BIT = 49;
	localparam int VEC_FC_BIT = 50;
	localparam int VEC_UC_LSB = 51;
	// ------------------------------------------------------------------
	// frame constants
	// ------------------------------------------------------------------
	localparam logic [7:0] PREAMBLE = 8'h55;
	localparam logic [7:0] SFD = 8'hd5;
	localparam logic [47:0] PAUSE_DA = 48'h010000c28001;
	localparam logic [15:0] PAUSE_TYPE = 16'h8808;
	localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
	localparam logic [5:0] PAUSE_LEN = 6'd60;
	localparam logic [3:0] PRE_BYTES = 4'd8;
	localparam logic [4:0] GAP_NIB = 5'd24;
	localparam logic [5:0] HDR_BYTES = 6'd14;
	// ------------------------------------------------------------------
	// state encodings
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		TX_IDLE = 4'b0001,
		TX_PRE = 4'b0010,
		TX_BODY = 4'b0100,
		TX_GAP = 4'b1000
	} mmac_tx_e;
	typedef enum logic [2:0] {
		RX_WAIT = 3'b001,
		RX_HUNT = 3'b010,
		RX_BODY = 3'b100
	} mmac_rx_e;
endpackage

// ---- logic/mmac_sync.sv ----
/*
 * Two-flop synchroniser with a third stage for edge detection.
 * Assumes inputs asynchronous to hclk; only stages two and three feed the edge logic.
 */
`timescale 1ns/100ps
module mmac_sync #(
	parameter int W = 1
) (
	input wire logic hclk, // system clock
	input wire logic hresetn, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous inputs
	output logic [W-1:0] q, // synchronised level
	output logic [W-1:0] rise, // one-cycle rising pulse
	output logic [W-1:0] fall // one-cycle falling pulse
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
		end else begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign q = s2_r;
	assign rise = s2_r & ~s3_r;
	assign fall = ~s2_r & s3_r;
endmodule

// ---- sim/mmac_phy_model.sv ----
/*
 * Nibble-wide PHY model: free-running tx clock, rx clock only around a frame,
 * tx nibble capture. Assumes the MAC drives tx pins after the tx clock falls.
 */
`timescale 1ns/100ps
module mmac_phy_model (
	output logic mii_tx_clk, // tx nibble clock
	input wire logic [3:0] mii_txd, // tx nibble
	input wire logic mii_tx_en, // tx enable
	output logic mii_rx_clk, // rx nibble clock
	output logic [3:0] mii_rxd, // rx nibble
	output logic mii_rx_dv, // rx data valid
	output logic mii_rx_er // rx error
);
	logic [3:0] txq[$];
	logic [7:0] rxb[0:63];
	initial begin
		mii_tx_clk = 1'b0;
		mii_rx_clk = 1'b0;
		mii_rxd = 4'h0;
		mii_rx_dv = 1'b0;
		mii_rx_er = 1'b0;
	end
	always #62.5 mii_tx_clk = ~mii_tx_clk;
	always @(posedge mii_tx_clk) begin
		if (mii_tx_en === 1'b1)
			txq.push_back(mii_txd);
	end
	// idle lead-in, data changes on rise, stable at the fall; clock stops after the frame
	task automatic rx_send(input int n);
		for (int i = -2; i < 20 + 2 * n; i++) begin
			#62.5 mii_rx_clk = 1'b1;
			mii_rx_dv = (i >= 0) && (i < 16 + 2 * n);
			if (i < 0)
				mii_rxd = 4'h0;
			else if (i < 16)
				mii_rxd = (i == 15) ? 4'hd : 4'h5;
			else if (i < 16 + 2 * n)
				mii_rxd = (i % 2) ? rxb[(i - 16) / 2][7:4] : rxb[(i - 16) / 2][3:0];
			else
				mii_rxd = ~mii_rxd;
			#62.5 mii_rx_clk = 1'b0;
		end
	endtask
endmodule

// ---- sim/mmac_top_tb.sv ----
/*
 * Self-checking bench for the nibble-wide MAC: registers, tx, pause, rx.
 * Assumes the top module in its register build with the unicast filter.
 */
`timescale 1ns/100ps
module mmac_top_tb import mmac_pkg::*;;
	typedef struct packed {logic [7:0] a; logic [31:0] w; logic [31:0] e;} mmac_row_s;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pause_req = 1'b0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [7:0] tx_axis_tdata = 8'h00, rx_axis_tdata;
	logic tx_axis_tvalid = 1'b0, tx_axis_tlast = 1'b0, hready, hreadyout, hresp;
	logic tx_axis_tready, rx_axis_tvalid, rx_axis_tlast, rx_axis_tuser, rx_pause, rx_da_match;
	logic mii_tx_clk, mii_tx_en, mii_rx_clk, mii_rx_dv, mii_rx_er, last_flag, last_user;
	logic [3:0] mii_txd, mii_rxd;
	logic [TXV_W-1:0] tx_cfg_vec = '0;
	logic [RXV_W-1:0] rx_cfg_vec = '0;
	logic [7:0] txb[0:63];
	logic [7:0] rxq[$];
	int mismatches = 0, samples_checked = 0, cycles = 0, pauses = 0;
	mmac_row_s rows[10] = '{'{REG_TX_CFG, 32'h9, 32'h9}, '{REG_RX_CFG, 32'h5, 32'h5},
		'{REG_TX_PA_LO, 32'h44332211, 32'h44332211}, '{REG_TX_PA_HI, 32'h6655, 32'h6655},
		'{REG_RX_PA_LO, 32'h44332211, 32'h44332211}, '{REG_RX_PA_HI, 32'h6655, 32'h6655},
		'{REG_UC_LO, 32'h0a090807, 32'h0a090807}, '{REG_UC_HI, 32'h0c0b, 32'h0c0b},
		'{8'h3c, 32'hffffffff, 32'h0}, '{REG_TX_CFG, 32'h3, 32'h3}};
	assign hready = hreadyout;
	mmac_top u_dut (.*);
	mmac_phy_model u_phy (.*);
	always #5 hclk = ~hclk;
	// ----------------------------------------
	// monitors and timeout
	// ----------------------------------------
	always @(posedge hclk) begin
		cycles++;
		if (rx_axis_tvalid === 1'b1) begin
			rxq.push_back(rx_axis_tdata);
			last_flag = rx_axis_tlast;
			last_user = rx_axis_tuser;
		end
		if (rx_pause === 1'b1)
			pauses++;
		if (cycles == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] v;
		bus(1'b1, a, d, v);
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] v;
		bus(1'b0, a, 32'h0, v);
		check(nm, e, v);
	endtask
	task automatic tx_send(input int n);
		int k;
		k = 0;
		tx_axis_tdata <= txb[0];
		tx_axis_tlast <= (n == 1);
		tx_axis_tvalid <= 1'b1;
		while (k < n) begin
			@(posedge hclk);
			if (tx_axis_tready === 1'b1) begin
				k++;
				tx_axis_tdata <= txb[k];
				tx_axis_tlast <= (k == n - 1);
				tx_axis_tvalid <= (k < n);
			end
		end
	endtask
	task automatic chk_tx(input int n);
		@(negedge mii_tx_en);
		check("tx nibbles", 32'(16 + 2 * n), 32'(u_phy.txq.size()));
		for (int i = 0; i < 16; i++)
			check("preamble", (i == 15) ? 32'hd : 32'h5, 32'(u_phy.txq[i]));
		for (int i = 0; i < n; i++)
			check("tx byte", 32'(txb[i]), 32'({u_phy.txq[17 + 2 * i], u_phy.txq[16 + 2 * i]}));
		u_phy.txq.delete();
	endtask
	task automatic pulse();
		@(posedge hclk);
		pause_req <= 1'b1;
		@(posedge hclk);
		pause_req <= 1'b0;
	endtask
	task automatic rx_run(input logic [47:0] da, input int n);
		rxq.delete();
		for (int i = 0; i < 16; i++)
			u_phy.rxb[i] = (i < 6) ? 8'(da >> (8 * i)) : 8'(i);
		u_phy.rxb[12] = 8'h88;
		u_phy.rxb[13] = 8'h08;
		u_phy.rx_send(n);
		repeat (20) @(posedge hclk);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge hclk);
		check("hreadyout", 32'h1, 32'(hreadyout));
		check("hresp", 32'h0, 32'(hresp));
		check("tready", 32'h0, 32'(tx_axis_tready));
		check("tx_en", 32'h0, 32'(mii_tx_en));
		$display("reset test done");
		hresetn <= 1'b1;
		rreg(REG_QUANTA, 32'hffff, "quanta reset");
		rreg(REG_TX_CFG, 32'h0, "tx cfg reset");
		foreach (rows[i]) begin
			wreg(rows[i].a, rows[i].w);
			rreg(rows[i].a, rows[i].e, "reg row");
		end
		$display("register test done");
		wreg(REG_QUANTA, 32'h1234);
		wreg(REG_TX_CFG, 32'h5);
		for (int i = 0; i < 4; i++)
			txb[i] = 8'(8'ha1 + 8'h11 * i);
		tx_send(4);
		chk_tx(4);
		$display("transmit test done");
		for (int i = 0; i < 60; i++)
			txb[i] = (i < 6) ? 8'(PAUSE_DA >> (8 * i)) : 8'h00;
		for (int k = 0; k < 6; k++)
			txb[6 + k] = 8'(48'h665544332211 >> (8 * k));
		{txb[12], txb[13], txb[14], txb[15], txb[16], txb[17]} = 48'h880800011234;
		pulse();
		chk_tx(60);
		wreg(REG_TX_CFG, 32'h7);
		pulse();
		repeat (600) @(posedge hclk);
		check("half duplex pause", 32'h0, 32'(u_phy.txq.size()));
		$display("pause transmit test done");
		rx_run(48'h0c0b0a090807, 16);
		check("rx bytes", 32'd16, 32'(rxq.size()));
		for (int i = 0; i < 16; i++)
			check("rx byte", 32'(u_phy.rxb[i]), 32'(rxq[i]));
		check("rx last", 32'h2, 32'({last_flag, last_user}));
		check("unicast hit", 32'h1, 32'(rx_da_match));
		rx_run(48'h665544332211, 16);
		check("pause seen", 32'h1, 32'(pauses));
		check("unicast miss", 32'h0, 32'(rx_da_match));
		wreg(REG_RX_CFG, 32'h7);
		rx_run(48'h665544332211, 16);
		check("half duplex rx pause", 32'h1, 32'(pauses));
		wreg(REG_RX_CFG, 32'h5);
		wreg(REG_UC_LO, 32'h44332211);
		wreg(REG_UC_HI, 32'h6655);
		rx_run(48'h665544332211, 16);
		check("shared pause", 32'h2, 32'(pauses));
		check("shared unicast", 32'h1, 32'(rx_da_match));
		rreg(REG_COUNT, 32'h00020000, "counts");
		$display("receive test done");
		wrap_up();
	end
endmodule
